// ---- pib_pkg.sv ----
package pib_pkg;
   localparam logic [2:0] PIB_DIV3 = 3'h2;
   localparam logic [2:0] PIB_DIV4 = 3'h3;
   localparam logic [2:0] PIB_DIV_RST = PIB_DIV4;
   localparam logic [7:0] PIB_CFG_DIV_IDX = 8'h50;
   localparam logic [3:0] PIB_CMD_CFG_RD = 4'hA;
   localparam logic [3:0] PIB_CMD_CFG_WR = 4'hB;
   localparam logic [1:0] PIB_CNT_THREE = 2'h2;
   localparam logic [1:0] PIB_CNT_FOUR = 2'h3;
   localparam logic [1:0] PIB_CNT_HALF3 = 2'h1;
   localparam logic [1:0] PIB_CNT_HALF4 = 2'h2;

   typedef enum logic [1:0] {
      PIB_IDLE = 2'b00,
      PIB_ADDR = 2'b01,
      PIB_DATA = 2'b10
   } pib_phase_t;

   typedef struct packed {
      logic frame_n;
      logic [3:0] cbe_n;
      logic [31:0] ad;
      logic idsel;
      logic irdy_n;
      logic trdy_n;
   } pib_bus_in_t;

   typedef struct packed {
      logic frame_n;
      logic frame_oe;
      logic [3:0] cbe_n;
      logic cbe_oe;
      logic [31:0] ad;
      logic ad_oe;
   } pib_bus_out_t;

   typedef struct packed {
      logic start;
      logic write;
      logic [3:0] cmd;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be_n;
      logic last;
   } pib_mreq_t;
endpackage

// ---- pib_clkdiv.sv ----
`timescale 1ns/1ps
`default_nettype none
module pib_clkdiv (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [2:0] div_code,
   output logic isa_bus_clock_out,
   output logic isa_tick
);
   import pib_pkg::*;
   logic [1:0] cnt;
   logic [1:0] top;
   logic [1:0] half;

   // Invalid codes fall back to divide by four rather than stopping the clock
   always_comb begin
      top = (div_code == PIB_DIV3) ? PIB_CNT_THREE : PIB_CNT_FOUR;
      half = (div_code == PIB_DIV3) ? PIB_CNT_HALF3 : PIB_CNT_HALF4;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt <= 2'h0;
      end else if (cnt >= top) begin
         cnt <= 2'h0;
      end else begin
         cnt <= cnt + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         isa_bus_clock_out <= 1'b0;
      end else begin
         isa_bus_clock_out <= (cnt < half);
      end
   end

   assign isa_tick = resetn && (cnt == 2'h0);

   a_div_wrap: assert property (@(posedge clk) disable iff (!resetn)
      (cnt == top && $stable(div_code)) |=> cnt == 2'h0)
      else $error("divider did not wrap");
endmodule
`default_nettype wire

// ---- pib_front_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module pib_front_end (
   input wire logic pci_bus_clock_in,
   input wire logic pci_reset_in_n,
   input wire pib_pkg::pib_bus_in_t bus_in,
   output pib_pkg::pib_bus_out_t bus_out,
   input wire pib_pkg::pib_mreq_t mreq,
   output logic m_busy,
   output logic [31:0] m_rdata,
   output logic m_rvalid,
   input wire logic [31:0] s_rdata,
   output logic s_cfg_hit,
   output logic s_cfg_write,
   output logic [31:0] s_addr,
   output logic [31:0] s_wdata,
   output logic s_wvalid,
   output logic [3:0] s_be_n,
   output logic isa_reset_out,
   output logic isa_bus_clock_out,
   output logic isa_tick
);
   import pib_pkg::*;
   logic clk;
   logic resetn;
   logic [2:0] div_code;
   pib_phase_t m_phase;
   pib_phase_t s_phase;
   logic m_write;
   logic m_last;
   logic s_rd;
   logic frame_q;
   logic [31:0] out_ad;
   logic [3:0] out_cbe_n;
   logic out_frame_n;

   function automatic logic is_cfg(input logic [3:0] cmd);
      is_cfg = (cmd == PIB_CMD_CFG_RD) || (cmd == PIB_CMD_CFG_WR);
   endfunction

   assign clk = pci_bus_clock_in;
   assign resetn = pci_reset_in_n;
   assign isa_reset_out = ~pci_reset_in_n;

   // Divisor field: loaded valid at reset, written by config write to 50h
   always_ff @(posedge clk) begin
      if (!resetn) begin
         div_code <= PIB_DIV_RST;
      end else if (s_phase == PIB_DATA && !s_rd && s_cfg_hit
                   && !bus_in.irdy_n
                   && s_addr[7:2] == PIB_CFG_DIV_IDX[7:2]
                   && !bus_in.cbe_n[0]) begin
         // Trusts software to write only the defined codes
         div_code <= bus_in.ad[2:0];
      end
   end

   pib_clkdiv u_div (
      .clk(clk),
      .resetn(resetn),
      .div_code(div_code),
      .isa_bus_clock_out(isa_bus_clock_out),
      .isa_tick(isa_tick)
   );

   // Master sequencer
   always_ff @(posedge clk) begin
      if (!resetn) begin
         m_phase <= PIB_IDLE;
         m_write <= 1'b0;
         m_last <= 1'b0;
      end else begin
         case (m_phase)
            PIB_IDLE: begin
               if (mreq.start && bus_in.frame_n && s_phase == PIB_IDLE) begin
                  m_phase <= PIB_ADDR;
                  m_write <= mreq.write;
                  m_last <= mreq.last;
               end
            end
            PIB_ADDR: begin
               m_phase <= PIB_DATA;
            end
            PIB_DATA: begin
               if (!bus_in.trdy_n) begin
                  if (m_last) begin
                     m_phase <= PIB_IDLE;
                  end
                  m_last <= mreq.last;
               end
            end
            default: m_phase <= PIB_IDLE;
         endcase
      end
   end

   assign m_busy = (m_phase != PIB_IDLE);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         out_ad <= 32'h0000_0000;
         out_cbe_n <= 4'hF;
         out_frame_n <= 1'b1;
      end else if (m_phase == PIB_IDLE && mreq.start && bus_in.frame_n
                   && s_phase == PIB_IDLE) begin
         out_ad <= mreq.addr;
         out_cbe_n <= mreq.cmd;
         out_frame_n <= 1'b0;
      end else if (m_phase != PIB_IDLE) begin
         if (m_phase == PIB_ADDR || !bus_in.trdy_n) begin
            out_ad <= mreq.wdata;
            out_cbe_n <= mreq.be_n;
            // Frame drops with the final data phase
            out_frame_n <= mreq.last || (m_phase == PIB_DATA && m_last);
         end
      end else if (s_phase == PIB_DATA && s_rd) begin
         out_ad <= s_rdata;
         out_frame_n <= 1'b1;
      end else begin
         out_frame_n <= 1'b1;
      end
   end

   // One process owns the whole output struct; values stay registered
   always_comb begin
      bus_out.ad = out_ad;
      bus_out.cbe_n = out_cbe_n;
      bus_out.frame_n = out_frame_n;
      bus_out.frame_oe = m_busy;
      bus_out.cbe_oe = m_busy;
      bus_out.ad_oe = (m_phase == PIB_ADDR)
         || (m_phase == PIB_DATA && m_write)
         || (s_phase == PIB_DATA && s_rd);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         m_rdata <= 32'h0000_0000;
         m_rvalid <= 1'b0;
      end else begin
         m_rvalid <= m_phase == PIB_DATA && !m_write && !bus_in.trdy_n
            && !bus_in.irdy_n;
         if (m_phase == PIB_DATA && !m_write && !bus_in.trdy_n) begin
            m_rdata <= bus_in.ad;
         end
      end
   end

   // Slave decode: a frame we did not start opens with the address
   always_ff @(posedge clk) begin
      frame_q <= resetn ? bus_in.frame_n : 1'b1;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_phase <= PIB_IDLE;
         s_rd <= 1'b0;
         s_cfg_hit <= 1'b0;
         s_cfg_write <= 1'b0;
         s_addr <= 32'h0000_0000;
      end else if (s_phase == PIB_IDLE) begin
         // Unselected config cycles belong to another agent
         if (!m_busy && !bus_in.frame_n && frame_q
             && (!is_cfg(bus_in.cbe_n) || bus_in.idsel)) begin
            s_phase <= PIB_DATA;
            s_addr <= bus_in.ad;
            s_rd <= !bus_in.cbe_n[0];
            s_cfg_hit <= is_cfg(bus_in.cbe_n) && bus_in.idsel;
            s_cfg_write <= bus_in.cbe_n == PIB_CMD_CFG_WR && bus_in.idsel;
         end
      end else if (bus_in.frame_n && !bus_in.irdy_n) begin
         s_phase <= PIB_IDLE;
         s_cfg_hit <= 1'b0;
         s_cfg_write <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_wdata <= 32'h0000_0000;
         s_be_n <= 4'hF;
         s_wvalid <= 1'b0;
      end else begin
         s_wvalid <= s_phase == PIB_DATA && !s_rd && !bus_in.irdy_n;
         if (s_phase == PIB_DATA) begin
            s_wdata <= bus_in.ad;
            s_be_n <= bus_in.cbe_n;
         end
      end
   end

   a_isa_reset_inv: assert property (@(posedge clk)
      isa_reset_out == !pci_reset_in_n)
      else $error("ISA reset not inverse of PCI reset");
   a_cbe_master_only: assert property (@(posedge clk)
      disable iff (!resetn)
      bus_out.cbe_oe |-> m_phase != PIB_IDLE)
      else $error("C/BE driven while not master");
   a_roles_exclusive: assert property (@(posedge clk)
      disable iff (!resetn)
      s_phase != PIB_IDLE |-> !bus_out.cbe_oe && !bus_out.frame_oe)
      else $error("master lines driven during slave transfer");
   a_master_rd_release: assert property (@(posedge clk)
      disable iff (!resetn)
      (m_phase == PIB_DATA && !m_write) |-> !bus_out.ad_oe)
      else $error("AD driven in master read data phase");
   a_master_addr_drive: assert property (@(posedge clk)
      disable iff (!resetn)
      (m_phase == PIB_IDLE && $past(m_phase) == PIB_IDLE && mreq.start
       && bus_in.frame_n && s_phase == PIB_IDLE) |=> bus_out.ad_oe
       && !bus_out.frame_n && bus_out.ad == $past(mreq.addr))
      else $error("address phase not driven");
   a_slave_wr_recv: assert property (@(posedge clk)
      disable iff (!resetn)
      (s_phase == PIB_DATA && !s_rd) |-> !bus_out.ad_oe)
      else $error("AD driven in slave write");
   a_cfg_needs_sel: assert property (@(posedge clk)
      disable iff (!resetn)
      (s_phase == PIB_IDLE && !m_busy && !bus_in.frame_n && frame_q
       && !bus_in.idsel) |=> !s_cfg_hit)
      else $error("config claimed without device select");
   a_cfg_unsel_quiet: assert property (@(posedge clk)
      disable iff (!resetn)
      (s_phase == PIB_IDLE && !m_busy && !bus_in.frame_n && frame_q
       && is_cfg(bus_in.cbe_n) && !bus_in.idsel) |=> s_phase == PIB_IDLE)
      else $error("unselected config cycle claimed");
   a_div_reset: assert property (@(posedge clk)
      !resetn |=> div_code == PIB_DIV4)
      else $error("divisor not reset to four");
   a_frame_end: assert property (@(posedge clk)
      disable iff (!resetn)
      (m_phase == PIB_DATA && m_last && !bus_in.trdy_n) |=>
      m_phase == PIB_IDLE)
      else $error("frame not ended after last data");
endmodule
`default_nettype wire

// ---- pib_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pib_far_model (
   input wire logic clk,
   input wire pib_pkg::pib_bus_out_t bus_out,
   input wire logic [1:0] waits,
   input wire logic [31:0] rdata,
   output logic trdy_n,
   output logic [31:0] ad
);
   import pib_pkg::*;
   logic dp = 1'b0;
   logic [1:0] cnt = 2'h0;
   logic [31:0] last_ad = 32'h0;
   // No answer in the address clock, only in data clocks and the one clock after frame_oe falls
   assign trdy_n = !(dp && cnt == waits);
   // Drive only once the master has let go; otherwise a toggling pattern
   assign ad = (dp && !bus_out.ad_oe) ? rdata : ~last_ad;
   always_ff @(posedge clk) begin
      dp <= bus_out.frame_oe;
      cnt <= (!dp || !trdy_n) ? 2'h0 : cnt + 2'h1;
      last_ad <= ad;
   end
endmodule
`default_nettype wire

// ---- pib_front_end_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pib_front_end_tb;
   import pib_pkg::*;
   localparam logic [31:0] FAR_D = 32'h5A5A_0F0F;
   logic clk, resetn, t_frame_n, t_ad_en, t_irdy_n, t_trdy_n, t_idsel;
   logic [3:0] t_cbe_n, s_be_n;
   logic [31:0] t_ad, s_rdata, far_ad, m_rdata, s_addr, s_wdata;
   logic [1:0] waits;
   logic far_trdy_n, m_busy, m_rvalid, s_cfg_hit, s_wvalid;
   logic isa_reset_out, isa_bus_clock_out, isa_tick, s_cfg_write;
   pib_bus_in_t bin;
   pib_bus_out_t bout;
   pib_mreq_t mreq;
   int err_total = 0;
   int tests_run = 0;

   always #12.5 clk = ~clk;
   // Undriven shared lines fall back to the pull-up or the far side
   always_comb begin
      bin.frame_n = bout.frame_oe ? bout.frame_n : t_frame_n;
      bin.cbe_n = bout.cbe_oe ? bout.cbe_n : t_cbe_n;
      bin.ad = bout.ad_oe ? bout.ad : (t_ad_en ? t_ad : far_ad);
      bin.idsel = t_idsel;
      bin.irdy_n = t_irdy_n;
      bin.trdy_n = far_trdy_n & t_trdy_n;
   end
   pib_far_model far (.clk(clk), .bus_out(bout), .waits(waits),
      .rdata(FAR_D), .trdy_n(far_trdy_n), .ad(far_ad));
   pib_front_end dut (.pci_bus_clock_in(clk), .pci_reset_in_n(resetn),
      .bus_in(bin), .bus_out(bout), .mreq(mreq), .m_busy(m_busy),
      .m_rdata(m_rdata), .m_rvalid(m_rvalid), .s_rdata(s_rdata),
      .s_cfg_hit(s_cfg_hit), .s_cfg_write(s_cfg_write), .s_addr(s_addr),
      .s_wdata(s_wdata), .s_wvalid(s_wvalid), .s_be_n(s_be_n),
      .isa_reset_out(isa_reset_out),
      .isa_bus_clock_out(isa_bus_clock_out), .isa_tick(isa_tick));

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("checks=%0d errors=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Counts PCI clocks between two rising edges of the ISA clock
   task automatic period(input int n);
      logic p;
      int c, r, tk;
      p = 1'b1;
      c = 0;
      r = 0;
      tk = 0;
      repeat (20) begin
         @(posedge clk);
         #1;
         if (r == 1) c++;
         if (r == 1 && isa_tick === 1'b1) tk++;
         if (isa_bus_clock_out === 1'b1 && !p) r++;
         p = isa_bus_clock_out;
      end
      check(c, n);
      check(tk, 1);
   endtask

   task automatic master(input logic w, input logic [3:0] cmd,
                         input logic [31:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      mreq <= '{start:1'b1, write:w, cmd:cmd, addr:a, wdata:d,
                be_n:4'h0, last:1'b1};
      t_irdy_n <= 1'b0;
      @(posedge clk);
      mreq.start <= 1'b0;
      #1;
      check(bin.frame_n, 1'b0);
      check(bout.ad, a);
      check({bout.ad_oe, bout.cbe_oe, bout.cbe_n}, {2'b11, cmd});
      @(posedge clk);
      #1;
      check({bout.ad_oe, bout.cbe_oe, bout.cbe_n}, {w, 5'h10});
      if (w) check(bout.ad, d);
      for (i = 0; i < 20 && m_busy !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      check({m_busy, bin.frame_n}, 2'b01);
      // Read data pulse stands in the cycle the master goes idle
      if (!w) check({m_rvalid, m_rdata}, {1'b1, FAR_D});
      else check(m_rvalid, 1'b0);
      @(posedge clk);
      t_irdy_n <= 1'b1;
   endtask

   task automatic slave(input logic [3:0] cmd, input logic [31:0] a,
                        input logic [31:0] d, input logic sel);
      @(posedge clk);
      t_frame_n <= 1'b0;
      t_cbe_n <= cmd;
      t_ad <= a;
      t_ad_en <= 1'b1;
      t_idsel <= sel;
      s_rdata <= d;
      @(posedge clk);
      t_frame_n <= 1'b1;
      t_cbe_n <= 4'h0;
      t_ad <= d;
      t_ad_en <= cmd[0];
      repeat (2) @(posedge clk);
      #1;
      check({s_cfg_hit, s_cfg_write, bout.cbe_oe, bout.ad_oe},
            {sel, cmd[0] & sel, 1'b0, !cmd[0]});
      if (!cmd[0]) check(bout.ad, d);
      @(posedge clk);
      t_irdy_n <= 1'b0;
      t_trdy_n <= 1'b0;
      @(posedge clk);
      t_irdy_n <= 1'b1;
      t_trdy_n <= 1'b1;
      t_ad_en <= 1'b0;
      t_idsel <= 1'b0;
      #1;
      check(s_wvalid, cmd[0] & sel);
      if (cmd[0] && sel) begin
         check({s_addr, s_wdata, s_be_n}, {a, d, 4'h0});
      end
      check({bout.ad_oe, bout.cbe_oe}, 2'b00);
   endtask

   // About 120 cycles of work; twenty times that is a hang
   initial begin
      #62_500;
      err_total++;
      close_out;
   end

   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      mreq = '0;
      {t_frame_n, t_irdy_n, t_trdy_n, t_ad_en, t_idsel} = 5'h1C;
      t_cbe_n = 4'hF;
      t_ad = 32'h0;
      s_rdata = 32'h0;
      waits = 2'h0;
      repeat (5) @(posedge clk);
      #1;
      check({isa_reset_out, bout.frame_oe, bout.cbe_oe, bout.ad_oe},
            4'h8);
      @(posedge clk);
      resetn <= 1'b1;
      #1;
      check(isa_reset_out, 1'b0);
      period(4);
      master(1'b1, 4'h7, 32'h1234_5678, 32'hCAFE_0001);
      waits <= 2'h2;
      master(1'b0, 4'h6, 32'h0000_0400, 32'h0);
      slave(PIB_CMD_CFG_WR, 32'h0000_0050, 32'h0000_0002, 1'b0);
      period(4);
      slave(PIB_CMD_CFG_WR, 32'h0000_0050, 32'h0000_0002, 1'b1);
      period(3);
      slave(PIB_CMD_CFG_RD, 32'h0000_0050, 32'hBEEF_0042, 1'b1);
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      #1;
      check(isa_reset_out, 1'b1);
      @(posedge clk);
      resetn <= 1'b1;
      period(4);
      close_out;
   end
endmodule
`default_nettype wire
